// [rtl/cmd_link_if.sv]
// Purpose: Command, bank and address wires between controller and memory.
// Assumes: Both ends share CLK; values change only after a rising edge.
// Notes: No clocking block; the bench joins the two ends through this.
`timescale 1ns/10ps
`default_nettype none
interface cmd_link_if;
  import mem_cmd_pkg::*;
  cmd_e cmd;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  modport dev (input cmd, input ba, input addr);
  modport ctl (output cmd, output ba, output addr);
endinterface
`default_nettype wire

// [rtl/event_history.sv]
// Purpose: Shift history of one-cycle events, used to time data windows.
// Assumes: Events are single-cycle pulses.
// Notes: Bit i is set when the event happened i + 1 cycles ago.
`timescale 1ns/10ps
`default_nettype none
module event_history
  import mem_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pulse,
  output logic [HIST_W-1:0] hist
);
  typedef struct packed {
    logic [HIST_W-1:0] sr;
  } hist_s;

  hist_s s;
  hist_s n;

  always_comb begin
    n.sr = {s.sr[HIST_W-2:0], pulse};
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign hist = s.sr;
endmodule
`default_nettype wire

// [rtl/mem_cmd_controller.sv]
// Purpose: Controller end: issues user commands and refreshes on the link.
// Assumes: User waits for CMD_READY before offering a command.
// Notes: Its own copy of the mode register steers format and spacing.
`timescale 1ns/10ps
`default_nettype none
module mem_cmd_controller
  import mem_cmd_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic CMD_VALID,
  input wire cmd_e CMD_OP,
  input wire logic [BANK_W-1:0] CMD_BANK,
  input wire logic [ADDR_W-1:0] CMD_ADDR,
  output logic CMD_READY,
  output logic CMD_REJECT,
  output logic MUX_MODE,
  output logic TERM_ON,
  cmd_link_if.ctl LNK
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic {CP_CMD, CP_SECOND} cphase_e;

  typedef struct packed {
    cphase_e phase;
    logic hold_v;
    cmd_e hold_cmd;
    logic [BANK_W-1:0] hold_ba;
    logic [ADDR_W-1:0] hold_addr;
    logic [ADDR_W-1:0] part2;
    logic [MODE_W-1:0] mode;
    logic [BANKS-1:0][BUSY_W-1:0] busy;
    logic [REF_CNT_W-1:0] ref_cnt;
    logic ref_pend;
    logic [BANK_W-1:0] ref_bank;
    logic ready;
    logic reject;
    cmd_e lnk_cmd;
    logic [BANK_W-1:0] lnk_ba;
    logic [ADDR_W-1:0] lnk_addr;
  } ctl_s;

  localparam ctl_s CTL_RST = '{phase: CP_CMD, hold_cmd: CMD_NOP, mode: MODE_RST,
                               lnk_cmd: CMD_NOP, default: '0};

  ctl_s s;
  ctl_s n;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [ADDR_W-1:0] a;
    logic [BUSY_W-1:0] rc;
    a = CMD_ADDR;
    rc = BUSY_W'(row_cycle(s.mode) - 1);
    n = s;
    n.lnk_cmd = CMD_NOP;
    n.lnk_ba = '0;
    n.lnk_addr = '0;
    n.reject = 1'b0;

    for (int b = 0; b < BANKS; b++) begin
      if (s.busy[b] != '0) begin
        n.busy[b] = s.busy[b] - 4'h1;
      end
    end

    // One refresh is due per interval, round robin over banks. see RL4
    if (s.ref_cnt == REF_LAST) begin
      n.ref_cnt = '0;
      n.ref_pend = 1'b1;
    end else begin
      n.ref_cnt = s.ref_cnt + 7'h01;
    end

    if (s.phase == CP_SECOND) begin
      n.phase = CP_CMD;
      n.lnk_addr = mux_part2(s.part2); // see RL9 see RL17
    end else if (s.ref_pend && s.busy[s.ref_bank] == '0) begin
      // Refresh is one link cycle even in two-part mode. see RL21
      n.lnk_cmd = CMD_AUTO_REFRESH;
      n.lnk_ba = s.ref_bank;
      // A refresh falling due in the cycle one is sent must not be lost.
      n.ref_pend = (s.ref_cnt == REF_LAST); // see RL4
      n.ref_bank = s.ref_bank + 3'h1;
      n.busy[s.ref_bank] = rc; // see RL3
    end else if (s.hold_v && s.busy[s.hold_ba] == '0) begin
      n.hold_v = 1'b0;
      n.lnk_cmd = s.hold_cmd;
      n.lnk_ba = s.hold_ba; // see RL11
      n.busy[s.hold_ba] = rc; // see RL3
      if (s.mode[MUX_BIT]) begin
        n.phase = CP_SECOND; // see RL12
        n.part2 = s.hold_addr;
        n.lnk_addr = mux_part1(s.hold_addr); // see RL13
      end else begin
        n.lnk_addr = s.hold_addr;
      end
      if (s.hold_cmd == CMD_MODE_LOAD) begin
        n.mode = s.hold_addr[MODE_W-1:0]; // see RL5
      end
    end

    if (CMD_VALID && s.ready && CMD_OP != CMD_NOP && CMD_OP != CMD_AUTO_REFRESH) begin
      if (CMD_OP == CMD_MODE_LOAD) begin
        a[ADDR_W-1:ZERO_LSB] = '0; // see RL14
        if (s.mode[MUX_BIT]) begin
          a[MUX_BIT] = 1'b1; // see RL16
        end
      end
      if (CMD_OP == CMD_MODE_LOAD && cfg_idx(a[MODE_W-1:0]) == 0 &&
          a[BURST_LSB +: 2] == BL8_CODE) begin
        n.reject = 1'b1; // see RL15
      end else begin
        n.hold_v = 1'b1;
        n.hold_cmd = CMD_OP;
        n.hold_ba = CMD_BANK;
        n.hold_addr = a;
      end
    end
    n.ready = !n.hold_v;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s <= CTL_RST;
    end else if (CE) begin
      s <= n;
    end
  end

  assign CMD_READY = s.ready;
  assign CMD_REJECT = s.reject;
  assign MUX_MODE = s.mode[MUX_BIT];
  assign TERM_ON = s.mode[TERM_BIT];
  assign LNK.cmd = s.lnk_cmd;
  assign LNK.ba = s.lnk_ba;
  assign LNK.addr = s.lnk_addr;

endmodule
`default_nettype wire

// [rtl/mem_cmd_device.sv]
// Purpose: Memory end of the command link: decode, mode, refresh, termination.
// Assumes: Controller keeps row cycle spacing and two-part address order.
// Notes: Data itself is outside this block; only its windows are produced.
//
// How it works
// RL1: Refresh one row of named bank only.
// RL2: Separate refresh row counter for every bank.
// RL3: Controller waits row cycle before same bank.
// RL4: Controller refreshes all rows each refresh period.
// RL5: Mode bit A9 turns termination on, off.
// RL6: Terminate data and mask, never command pins.
// RL7: Read termination off around driven read beats.
// RL8: Write data and mask termination always on.
// RL9: Multiplexed address arrives over two consecutive edges.
// RL10: Multiplexed mode uses eleven address balls only.
// RL11: Bank comes with command and first part.
// RL12: Mode bit A5 selects two-part address format.
// RL13: Multiplexed mode load uses six field balls.
// RL14: Upper mode load address bits driven zero.
// RL15: Never burst eight with configuration one.
// RL16: Every multiplexed mode load keeps A5 high.
// RL17: Fixed ball map for first, second part.
// RL18: Second part A0 only x9 burst two.
// RL19: Multiplexed read latency is five, seven, nine.
// RL20: Multiplexed write latency six, eight, ten.
// RL21: Refresh takes one cycle, next command follows.
// RL22: Mode load stores address bits seventeen to zero.
// RL23: Advance bank row counter after each refresh.
//
`timescale 1ns/10ps
`default_nettype none
module mem_cmd_device
  import mem_cmd_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  cmd_link_if.dev LNK,
  output logic OP_VALID,
  output logic OP_WRITE,
  output logic [BANK_W-1:0] OP_BANK,
  output logic [ADDR_W-1:0] OP_ADDR,
  output logic REF_VALID,
  output logic [BANK_W-1:0] REF_BANK,
  output logic [ROW_W-1:0] REF_ROW,
  output logic Q_DRIVE,
  output logic Q_TERM_EN,
  output logic D_TERM_EN,
  output logic W_CAPTURE,
  output logic MUX_MODE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic {PH_CMD, PH_SECOND} phase_e;

  typedef struct packed {
    phase_e phase;
    cmd_e pend_cmd;
    logic [BANK_W-1:0] pend_ba;
    logic [ADDR_W-1:0] pend_part1;
    logic [MODE_W-1:0] mode;
    logic [BANKS-1:0][ROW_W-1:0] rows;
    logic op_valid;
    logic op_write;
    logic [BANK_W-1:0] op_bank;
    logic [ADDR_W-1:0] op_addr;
    logic ref_valid;
    logic [BANK_W-1:0] ref_bank;
    logic [ROW_W-1:0] ref_row;
    logic q_drive;
    logic q_term;
    logic d_term;
    logic w_capture;
  } dev_s;

  localparam dev_s DEV_RST = '{phase: PH_CMD, pend_cmd: CMD_NOP, mode: MODE_RST,
                               default: '0};

  dev_s s;
  dev_s n;
  logic rd_start;
  logic wr_start;
  logic [HIST_W-1:0] rd_hist;
  logic [HIST_W-1:0] wr_hist;

  // ----------------------------------------------------------------
  // Data window timing
  // ----------------------------------------------------------------
  event_history u_rd_hist (
    .clk(CLK),
    .rstn(RSTN),
    .ce(CE),
    .pulse(rd_start),
    .hist(rd_hist)
  );

  event_history u_wr_hist (
    .clk(CLK),
    .rstn(RSTN),
    .ce(CE),
    .pulse(wr_start),
    .hist(wr_hist)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ex_v;
    cmd_e ex_cmd;
    logic [BANK_W-1:0] ex_ba;
    logic [ADDR_W-1:0] ex_a;
    logic x9_bl2;
    logic rd_win;
    logic wr_win;
    logic q_off;
    int rd_lat;
    int wr_lat;
    int nb;
    int d;
    ex_v = 1'b0;
    ex_cmd = CMD_NOP;
    ex_ba = '0;
    ex_a = '0;
    rd_win = 1'b0;
    wr_win = 1'b0;
    q_off = 1'b0;
    rd_start = 1'b0;
    wr_start = 1'b0;
    x9_bl2 = DATA_X9 && (s.mode[BURST_LSB +: 2] == BL2_CODE);
    rd_lat = read_lat(s.mode); // see RL19
    wr_lat = write_lat(s.mode); // see RL20
    nb = beats(s.mode);
    d = s.mode[MUX_BIT] ? 1 : 0;
    n = s;
    n.op_valid = 1'b0;
    n.ref_valid = 1'b0;

    case (s.phase)
      PH_CMD: begin
        case (LNK.cmd)
          CMD_AUTO_REFRESH: begin
            // Only the bank is used, so no second part follows. see RL21
            n.ref_valid = 1'b1; // see RL1
            n.ref_bank = LNK.ba;
            n.ref_row = s.rows[LNK.ba]; // see RL2
            n.rows[LNK.ba] = s.rows[LNK.ba] + 13'h0001; // see RL23
          end
          CMD_READ, CMD_WRITE, CMD_MODE_LOAD: begin
            if (s.mode[MUX_BIT]) begin
              // Bank and first part are taken with the command. see RL9 see RL12
              n.phase = PH_SECOND;
              n.pend_cmd = LNK.cmd;
              n.pend_ba = LNK.ba;
              n.pend_part1 = mux_part1(LNK.addr); // see RL10
            end else begin
              ex_v = 1'b1;
              ex_cmd = LNK.cmd;
              ex_ba = LNK.ba;
              ex_a = LNK.addr;
            end
          end
          default: begin
          end
        endcase
      end
      PH_SECOND: begin
        // The command pins are ignored while the second part is taken.
        n.phase = PH_CMD;
        ex_v = 1'b1;
        ex_cmd = s.pend_cmd;
        ex_ba = s.pend_ba;
        ex_a = mux_join(s.pend_part1, LNK.addr, x9_bl2); // see RL17 see RL18
      end
      default: begin
        n.phase = PH_CMD;
      end
    endcase

    if (ex_v) begin
      case (ex_cmd)
        CMD_MODE_LOAD: begin
          n.mode = ex_a[MODE_W-1:0]; // see RL22
        end
        CMD_READ: begin
          n.op_valid = 1'b1;
          n.op_write = 1'b0;
          n.op_bank = ex_ba;
          n.op_addr = ex_a;
          rd_start = 1'b1;
        end
        CMD_WRITE: begin
          n.op_valid = 1'b1;
          n.op_write = 1'b1;
          n.op_bank = ex_ba;
          n.op_addr = ex_a;
          wr_start = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Windows count from the command edge; a two-part start is one later.
    for (int i = 0; i < HIST_W; i++) begin
      if (rd_hist[i] && i >= rd_lat - 2 - d && i <= rd_lat - 3 - d + nb) begin
        rd_win = 1'b1;
      end
      if (rd_hist[i] && i >= rd_lat - 3 - d && i <= rd_lat - 3 - d + nb) begin
        q_off = 1'b1;
      end
      if (wr_hist[i] && i >= wr_lat - 2 - d && i <= wr_lat - 3 - d + nb) begin
        wr_win = 1'b1;
      end
    end

    // A latency change by a mode load moves windows of reads in flight.
    n.q_drive = rd_win;
    n.q_term = n.mode[TERM_BIT] && !q_off; // see RL5 see RL7
    n.d_term = n.mode[TERM_BIT]; // see RL6 see RL8
    n.w_capture = wr_win;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s <= DEV_RST;
    end else if (CE) begin
      s <= n;
    end
  end

  assign OP_VALID = s.op_valid;
  assign OP_WRITE = s.op_write;
  assign OP_BANK = s.op_bank;
  assign OP_ADDR = s.op_addr;
  assign REF_VALID = s.ref_valid;
  assign REF_BANK = s.ref_bank;
  assign REF_ROW = s.ref_row;
  assign Q_DRIVE = s.q_drive;
  assign Q_TERM_EN = s.q_term;
  assign D_TERM_EN = s.d_term;
  assign W_CAPTURE = s.w_capture;
  assign MUX_MODE = s.mode[MUX_BIT];

endmodule
`default_nettype wire

// [rtl/mem_cmd_pkg.sv]
// Purpose: Shared constants, types and address helpers for the command link.
// Assumes: One clock for both ends; configuration comes only from mode loads.
// Notes: The data width strap is fixed here for the whole design.
package mem_cmd_pkg;

  // ----------------------------------------------------------------
  // Widths and mode register layout
  // ----------------------------------------------------------------
  localparam int BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 21;
  localparam int MODE_W = 18;
  localparam int ROW_W = 13;
  localparam int HIST_W = 16;
  localparam int BUSY_W = 4;
  localparam int CFG_LSB = 0;
  localparam int CFG_W = 3;
  localparam int BURST_LSB = 3;
  localparam int MUX_BIT = 5;
  localparam int TERM_BIT = 9;
  localparam int ZERO_LSB = 10;
  localparam logic [MODE_W-1:0] MODE_RST = 18'h00000;
  localparam logic [1:0] BL2_CODE = 2'h0;
  localparam logic [1:0] BL4_CODE = 2'h1;
  localparam logic [1:0] BL8_CODE = 2'h2;
  localparam logic DATA_X9 = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RC_CYC [3] = '{4, 6, 8};
  localparam int RDLAT_CYC [3] = '{4, 6, 8};
  localparam int MUX_EXTRA = 1;
  localparam int WRLAT_EXTRA = 1;
  localparam int CLK_MHZ = 125;
  localparam int REFRESH_PERIOD_MS = 32;
  localparam int ROWS_PER_BANK = 8192;
  localparam int REF_INTERVAL_CYC =
    REFRESH_PERIOD_MS * 1000 * CLK_MHZ / (ROWS_PER_BANK * BANKS);
  localparam int REF_CNT_W = 7;
  localparam logic [REF_CNT_W-1:0] REF_LAST = REF_CNT_W'(REF_INTERVAL_CYC - 1);

  // ----------------------------------------------------------------
  // Two-part address ball map
  // ----------------------------------------------------------------
  localparam int MUX_BALLS = 11;
  localparam int BALL_POS [MUX_BALLS] = '{0, 3, 4, 5, 8, 9, 10, 13, 14, 17, 18};
  localparam int PART2_POS [MUX_BALLS] = '{-1, 1, 2, -1, 6, 7, 19, 11, 12, 16, 15};
  localparam int A20_POS = 20;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_READ, CMD_WRITE, CMD_MODE_LOAD, CMD_AUTO_REFRESH
  } cmd_e;

  function automatic int cfg_idx(input logic [MODE_W-1:0] m);
    case (m[CFG_LSB +: CFG_W])
      3'h2: return 1;
      3'h3: return 2;
      default: return 0;
    endcase
  endfunction

  function automatic int beats(input logic [MODE_W-1:0] m);
    case (m[BURST_LSB +: 2])
      BL4_CODE: return 2;
      BL8_CODE: return 4;
      default: return 1;
    endcase
  endfunction

  function automatic int read_lat(input logic [MODE_W-1:0] m);
    return RDLAT_CYC[cfg_idx(m)] + (m[MUX_BIT] ? MUX_EXTRA : 0);
  endfunction

  function automatic int write_lat(input logic [MODE_W-1:0] m);
    return read_lat(m) + WRLAT_EXTRA;
  endfunction

  function automatic int row_cycle(input logic [MODE_W-1:0] m);
    return RC_CYC[cfg_idx(m)];
  endfunction

  function automatic logic [ADDR_W-1:0] mux_part1(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] x;
    x = '0;
    for (int k = 0; k < MUX_BALLS; k++) begin
      x[BALL_POS[k]] = a[BALL_POS[k]];
    end
    return x;
  endfunction

  function automatic logic [ADDR_W-1:0] mux_part2(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] y;
    y = '0;
    for (int k = 0; k < MUX_BALLS; k++) begin
      if (PART2_POS[k] >= 0) begin
        y[BALL_POS[k]] = a[PART2_POS[k]];
      end
    end
    y[0] = a[A20_POS];
    return y;
  endfunction

  function automatic logic [ADDR_W-1:0] mux_join(input logic [ADDR_W-1:0] p1,
                                                 input logic [ADDR_W-1:0] p2,
                                                 input logic x9_bl2);
    logic [ADDR_W-1:0] a;
    a = '0;
    for (int k = 0; k < MUX_BALLS; k++) begin
      a[BALL_POS[k]] = p1[BALL_POS[k]];
      if (PART2_POS[k] >= 0) begin
        a[PART2_POS[k]] = p2[BALL_POS[k]];
      end
    end
    if (x9_bl2) begin
      a[A20_POS] = p2[0];
    end
    return a;
  endfunction

endpackage

// [sim/mem_cmd_link_sva.sv]
// Purpose: Concurrent checks on the command link and the memory end outputs.
// Assumes: One clock; inputs are the link wires and device outputs.
// Notes: Mode effects get four cycles to show, no more than the closest mode load spacing.
`timescale 1ns/10ps
`default_nettype none
module mem_cmd_link_sva
  import mem_cmd_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire cmd_e cmd,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic MUX_MODE,
  input wire logic OP_VALID,
  input wire logic [BANK_W-1:0] OP_BANK,
  input wire logic [ADDR_W-1:0] OP_ADDR,
  input wire logic REF_VALID,
  input wire logic [BANK_W-1:0] REF_BANK,
  input wire logic Q_DRIVE,
  input wire logic Q_TERM_EN,
  input wire logic D_TERM_EN
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BALL_MASK = 21'h066739;
  logic term_q;
  logic mux_q;
  logic rw;
  assign rw = (cmd == CMD_READ) || (cmd == CMD_WRITE);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      term_q <= 1'b0;
      mux_q <= 1'b0;
    end else if (cmd == CMD_MODE_LOAD) begin
      term_q <= addr[TERM_BIT];
      mux_q <= addr[MUX_BIT];
    end
  end
  property same_bank_gap;
    cmd != CMD_NOP |=> !(cmd != CMD_NOP && ba == $past(ba))
      ##1 !(cmd != CMD_NOP && ba == $past(ba, 2)) ##1 !(cmd != CMD_NOP && ba == $past(ba, 3));
  endproperty
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_MODE_UPPER_ZERO: assert property (cmd == CMD_MODE_LOAD |-> addr[20:10] == 11'h000)
    else $error("mode load upper bits not zero");
  AST_MODE_KEEPS_MUX: assert property (cmd == CMD_MODE_LOAD && MUX_MODE |-> addr[MUX_BIT])
    else $error("mode load in two-part mode lost the mux bit");
  AST_MODE_APPLIES: assert property (cmd == CMD_MODE_LOAD |-> ##4 (D_TERM_EN == term_q && MUX_MODE == mux_q))
    else $error("mode load did not take effect");
  AST_REFRESH_BANK: assert property (cmd == CMD_AUTO_REFRESH |=> REF_VALID && REF_BANK == $past(ba))
    else $error("refresh not done on named bank");
  AST_OP_NORMAL: assert property (!MUX_MODE && rw |=> OP_VALID && OP_ADDR == $past(addr))
    else $error("single-part access not executed");
  AST_OP_MUX: assert property (MUX_MODE && rw |-> ##1 cmd == CMD_NOP ##1 OP_VALID && OP_BANK == $past(ba, 2))
    else $error("two-part access not executed after second edge");
  AST_ELEVEN_BALLS: assert property (MUX_MODE && rw |-> (addr & ~BALL_MASK) == 0 ##1 (addr & ~BALL_MASK) == 0)
    else $error("address outside the eleven balls");
  AST_BANK_SPACING: assert property (same_bank_gap)
    else $error("same bank addressed within row cycle");
  AST_TERM_OFF_DRIVE: assert property (Q_DRIVE |-> !Q_TERM_EN)
    else $error("read termination on while driving");
  AST_TERM_BEFORE: assert property ($rose(Q_DRIVE) |-> $past(Q_TERM_EN) == 1'b0)
    else $error("read termination not off before driving");
  AST_TERM_BACK: assert property ($fell(Q_DRIVE) && D_TERM_EN |-> Q_TERM_EN or (##1 Q_DRIVE))
    else $error("read termination not back after last beat");
  AST_WRITE_TERM: assert property (Q_DRIVE |-> $stable(D_TERM_EN))
    else $error("write termination moved during read");
  COV_MUX_REF_NEXT: cover property (cmd == CMD_AUTO_REFRESH && MUX_MODE ##1 cmd != CMD_NOP);
  COV_MUX_RW: cover property (MUX_MODE && rw ##2 OP_VALID);
  COV_TERM_READ: cover property (D_TERM_EN && $rose(Q_DRIVE));
endmodule
`default_nettype wire

// [sim/muxed_address_refresh_cmd_tb_top.sv]
// Purpose: Joins controller and memory ends and drives the user port.
// Assumes: CE held high; both ends share the clock.
// Notes: Latency is counted from the cycle a command shows on the link.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module muxed_address_refresh_cmd_tb_top
  import mem_cmd_pkg::*;
();
  logic clk, rstn, ce, cmd_valid, cmd_ready, cmd_reject, ctl_mux, ctl_term;
  logic op_valid, op_write, ref_valid, q_drive, q_term_en, d_term_en, w_capture, dev_mux;
  cmd_e cmd_op;
  cmd_e lnk_cmd;
  logic [BANK_W-1:0] cmd_bank, op_bank, ref_bank, lnk_ba;
  logic [ADDR_W-1:0] cmd_addr, op_addr, lnk_addr;
  logic [ROW_W-1:0] ref_row;
  int err_count = 0;
  int checks = 0;
  int exp_row [BANKS] = '{default: 0};
  int ball [11] = '{0, 3, 4, 5, 8, 9, 10, 13, 14, 17, 18};
  int ysrc [11] = '{-1, 1, 2, -1, 6, 7, 19, 11, 12, 16, 15};
  logic [2:0] cfgv [3] = '{3'h0, 3'h2, 3'h3};
  logic [1:0] blv [3] = '{BL2_CODE, BL4_CODE, BL8_CODE};
  int rlv [3] = '{5, 7, 9};
  int nbv [3] = '{1, 2, 4};
  cmd_link_if cmd_link_if_inst ();
  assign lnk_cmd = cmd_link_if_inst.cmd;
  assign lnk_ba = cmd_link_if_inst.ba;
  assign lnk_addr = cmd_link_if_inst.addr;
  mem_cmd_controller mem_cmd_controller_inst (.CLK(clk), .RSTN(rstn), .CE(ce),
    .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_BANK(cmd_bank), .CMD_ADDR(cmd_addr),
    .CMD_READY(cmd_ready), .CMD_REJECT(cmd_reject), .MUX_MODE(ctl_mux), .TERM_ON(ctl_term),
    .LNK(cmd_link_if_inst));
  mem_cmd_device mem_cmd_device_inst (.CLK(clk), .RSTN(rstn), .CE(ce), .LNK(cmd_link_if_inst),
    .OP_VALID(op_valid), .OP_WRITE(op_write), .OP_BANK(op_bank), .OP_ADDR(op_addr),
    .REF_VALID(ref_valid), .REF_BANK(ref_bank), .REF_ROW(ref_row), .Q_DRIVE(q_drive),
    .Q_TERM_EN(q_term_en), .D_TERM_EN(d_term_en), .W_CAPTURE(w_capture), .MUX_MODE(dev_mux));
  mem_cmd_link_sva mem_cmd_link_sva_inst (.CLK(clk), .RSTN(rstn), .cmd(lnk_cmd), .ba(lnk_ba),
    .addr(lnk_addr), .MUX_MODE(dev_mux), .OP_VALID(op_valid), .OP_BANK(op_bank),
    .OP_ADDR(op_addr), .REF_VALID(ref_valid), .REF_BANK(ref_bank), .Q_DRIVE(q_drive),
    .Q_TERM_EN(q_term_en), .D_TERM_EN(d_term_en));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // The leading tick lets a just-taken offer pull READY low before it is sampled again.
  task automatic issue(input cmd_e op, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    tick();
    while (cmd_ready !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_bank <= b;
    cmd_addr <= a;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task automatic wait_link(input cmd_e op);
    int n;
    n = 0;
    while (lnk_cmd !== op && n < 60) begin
      tick();
      n++;
    end
    `CHK("link command", op, lnk_cmd)
  endtask
  task automatic mode(input logic [2:0] cfg, input logic [1:0] burst, input logic mx,
                      input logic term);
    logic keep;
    keep = dev_mux | mx;
    issue(CMD_MODE_LOAD, 3'h0, {11'h000, term, 3'h0, mx, burst, cfg});
    wait_link(CMD_MODE_LOAD);
    repeat (5) tick();
    `CHK("device mux", keep, dev_mux)
    `CHK("ctl mux", keep, ctl_mux)
    `CHK("data term", term, d_term_en)
    `CHK("ctl term", term, ctl_term)
  endtask
  task automatic xfer(input cmd_e op, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a,
                      input int lat, input int nb);
    int first;
    int cnt;
    logic mx;
    logic [ADDR_W-1:0] ex;
    first = 0;
    cnt = 0;
    mx = dev_mux;
    ex = mx ? {1'b0, a[19:0]} : a;
    issue(op, b, a);
    wait_link(op);
    `CHK("link bank", b, lnk_ba)
    for (int k = 0; k < 11; k++) begin
      if (mx) `CHK("first part", a[ball[k]], lnk_addr[ball[k]])
    end
    for (int n = 1; n < 32; n++) begin
      tick();
      for (int k = 0; k < 11; k++) begin
        if (mx && n == 1 && ysrc[k] >= 0) `CHK("second part", a[ysrc[k]], lnk_addr[ball[k]])
      end
      if (op_valid === 1'b1) begin
        `CHK("op bank", b, op_bank)
        `CHK("op addr", ex, op_addr)
        `CHK("op write", op == CMD_WRITE, op_write)
      end
      if ((op == CMD_WRITE ? w_capture : q_drive) === 1'b1) begin
        if (first == 0) first = n;
        cnt++;
      end
    end
    `CHK("latency", lat, first)
    `CHK("beats", nb, cnt)
  endtask
  // ----------------------------------------------------------------
  // Clock, refresh monitor, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    if (rstn === 1'b1 && ref_valid === 1'b1) begin
      `CHK("refresh row", exp_row[ref_bank], ref_row)
      exp_row[ref_bank] = exp_row[ref_bank] + 1;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    logic seen;
    rstn = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = CMD_NOP;
    cmd_bank = '0;
    cmd_addr = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    xfer(CMD_READ, 3'h1, 21'h1ABCDE, 4, 1);
    xfer(CMD_WRITE, 3'h2, 21'h0F0F0F, 5, 1);
    mode(3'h0, BL4_CODE, 1'b0, 1'b1);
    xfer(CMD_READ, 3'h3, 21'h012345, 4, 2);
    for (int c = 0; c < 8; c++) begin
      if (c != 2 && c != 3) begin
        issue(CMD_MODE_LOAD, 3'h0, {16'h0000, BL8_CODE, 3'(c)});
        seen = 1'b0;
        repeat (3) begin
          if (cmd_reject === 1'b1) seen = 1'b1;
          tick();
        end
        `CHK("reject", 1'b1, seen)
      end
    end
    `CHK("term kept", 1'b1, d_term_en)
    mode(3'h0, BL2_CODE, 1'b1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      mode(cfgv[i], blv[i], 1'b1, 1'b1);
      xfer(CMD_READ, 3'(i + 4), 21'h1FFFFF ^ (21'h012345 << i), rlv[i], nbv[i]);
      xfer(CMD_WRITE, 3'(i), 21'h155555 + 21'(i), rlv[i] + 1, nbv[i]);
    end
    mode(3'h3, BL4_CODE, 1'b0, 1'b0);
    issue(CMD_READ, 3'h5, 21'h000111);
    issue(CMD_READ, 3'h5, 21'h000222);
    repeat (600) tick();
    `CHK("rows advanced", 1'b1, exp_row[0] > 1)
    tally_and_finish();
  end
endmodule
`default_nettype wire
